// *** hdl/rtc_alarm_compare.v ***
// Summary of operation
// - each alarm byte mirrors its calendar byte, msb is the byte's enable.
// - only enabled bytes are compared; any subset may be enabled.
// - there is no year byte, the year never takes part in a match.
// - an alarm fires when freq out is off, one or more bytes are enabled and every enabled byte equals the calendar byte.
// - single event match sets the flag and holds the pin low till cleared.
// - with repeat set the pin pulses on every match, indefinitely.
// - with auto clear set, a status read clears the flag unless a match sets it in the same cycle.
// - without seconds, match fires as seconds roll over to 00.
// - in repeat mode the flag sets on every match, no clearing needed.
`timescale 1ns/1ps
`include "rtc_alarm_map.vh"
module rtc_alarm_compare
(
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // timekeeping tick, 32.768 kHz domain, taken through a synchroniser
  input wire tick_i,
  // calendar bytes, stable between ticks, year not wired in
  input wire [6:0] cal_seconds_i,
  input wire [6:0] cal_minutes_i,
  input wire [6:0] cal_hours_i,
  input wire [6:0] cal_date_i,
  input wire [6:0] cal_month_i,
  input wire [6:0] cal_weekday_i,
  // byte-wide register port
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // interrupt pin, active low
  output reg interrupt_or_freq_pin_n_o
);
  reg [7:0] alarm_seconds;
  reg [7:0] alarm_minutes;
  reg [7:0] alarm_hours;
  reg [7:0] alarm_date;
  reg [7:0] alarm_month;
  reg [7:0] alarm_weekday;
  reg auto_clear_on_read;
  reg alarm_flag;
  reg repeat_select;
  reg freq_out_en;
  reg latched_low;
  reg [`PULSE_CNT_W-1:0] pulse_cnt;
  reg prev_match;
  reg [7:0] next_rdata;
  wire tick;
  wire [5:0] en;
  wire [5:0] eq;
  wire match_now;
  wire fire;
  wire flag_write;
  wire status_read;
  wire wr_sec;
  wire wr_min;
  wire wr_hr;
  wire wr_date;
  wire wr_mon;
  wire wr_wday;
  wire wr_status;
  wire wr_ctrl;
  wire pulse_busy;
  wire single_fire;
  wire repeat_fire;
  // reset images of the two control registers
  localparam [7:0] STATUS_RST = `RST_STATUS;
  localparam [7:0] CTRL_RST = `RST_INT_CTRL;
  localparam [`PULSE_CNT_W-1:0] PULSE_ZERO = {`PULSE_CNT_W{1'b0}};

  edge_sync u_tick
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(tick_i),
    .rise_o(tick)
  );

  byte_match u_sec
  (
    .alarm_byte_i(alarm_seconds),
    .calendar_byte_i(cal_seconds_i),
    .enabled_o(en[0]),
    .equal_o(eq[0])
  );
  byte_match u_min
  (
    .alarm_byte_i(alarm_minutes),
    .calendar_byte_i(cal_minutes_i),
    .enabled_o(en[1]),
    .equal_o(eq[1])
  );
  byte_match u_hr
  (
    .alarm_byte_i(alarm_hours),
    .calendar_byte_i(cal_hours_i),
    .enabled_o(en[2]),
    .equal_o(eq[2])
  );
  byte_match u_date
  (
    .alarm_byte_i(alarm_date),
    .calendar_byte_i(cal_date_i),
    .enabled_o(en[3]),
    .equal_o(eq[3])
  );
  byte_match u_mon
  (
    .alarm_byte_i(alarm_month),
    .calendar_byte_i(cal_month_i),
    .enabled_o(en[4]),
    .equal_o(eq[4])
  );
  byte_match u_wday
  (
    .alarm_byte_i(alarm_weekday),
    .calendar_byte_i(cal_weekday_i),
    .enabled_o(en[5]),
    .equal_o(eq[5])
  );

  // no year comparator exists at all
  assign match_now = (|en) & (&eq);
  // fire on entry into a match; without seconds this is the 59->00 roll
  // seen on the synchronised copy of the same tick that updates the calendar
  assign fire = match_now & ~prev_match & ~freq_out_en;
  assign flag_write = reg_wr_i & (reg_addr_i == `ADDR_STATUS);
  assign status_read = reg_rd_i & (reg_addr_i == `ADDR_STATUS);
  // one strobe per register keeps each write process small
  assign wr_sec = reg_wr_i & (reg_addr_i == `ADDR_ALARM_SECONDS);
  assign wr_min = reg_wr_i & (reg_addr_i == `ADDR_ALARM_MINUTES);
  assign wr_hr = reg_wr_i & (reg_addr_i == `ADDR_ALARM_HOURS);
  assign wr_date = reg_wr_i & (reg_addr_i == `ADDR_ALARM_DATE);
  assign wr_mon = reg_wr_i & (reg_addr_i == `ADDR_ALARM_MONTH);
  assign wr_wday = reg_wr_i & (reg_addr_i == `ADDR_ALARM_WEEKDAY);
  assign wr_status = flag_write;
  assign wr_ctrl = reg_wr_i & (reg_addr_i == `ADDR_INT_CTRL);
  // split by mode so level and pulse logic never both start
  assign single_fire = tick & fire & ~repeat_select;
  assign repeat_fire = tick & fire & repeat_select;
  assign pulse_busy = (pulse_cnt != PULSE_ZERO);

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prev_match <= 1'b0;
    else if (tick)
      prev_match <= match_now;
  end

  // time of day alarm bytes, written whole with their enable bit
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alarm_seconds <= `RST_ALARM_BYTE;
      alarm_minutes <= `RST_ALARM_BYTE;
      alarm_hours <= `RST_ALARM_BYTE;
    end
    else
    begin
      if (wr_sec)
        alarm_seconds <= reg_wdata_i;
      if (wr_min)
        alarm_minutes <= reg_wdata_i;
      if (wr_hr)
        alarm_hours <= reg_wdata_i;
    end
  end

  // calendar day alarm bytes
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alarm_date <= `RST_ALARM_BYTE;
      alarm_month <= `RST_ALARM_BYTE;
      alarm_weekday <= `RST_ALARM_BYTE;
    end
    else
    begin
      if (wr_date)
        alarm_date <= reg_wdata_i;
      if (wr_mon)
        alarm_month <= reg_wdata_i;
      if (wr_wday)
        alarm_weekday <= reg_wdata_i;
    end
  end

  // status control bit; the flag bit has its own process
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      auto_clear_on_read <= STATUS_RST[`BIT_AUTO_CLEAR];
    else if (wr_status)
      auto_clear_on_read <= reg_wdata_i[`BIT_AUTO_CLEAR];
  end

  // freq output resets on, so nothing fires before the host is ready
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      repeat_select <= CTRL_RST[`BIT_REPEAT_SELECT];
      freq_out_en <= CTRL_RST[`BIT_FREQ_OUT_EN];
    end
    else if (wr_ctrl)
    begin
      repeat_select <= reg_wdata_i[`BIT_REPEAT_SELECT];
      freq_out_en <= reg_wdata_i[`BIT_FREQ_OUT_EN];
    end
  end

  // flag: set wins over write-0 or read-clear in the same cycle
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alarm_flag <= 1'b0;
    else if (tick & fire)
      alarm_flag <= 1'b1;
    else if (flag_write & ~reg_wdata_i[`BIT_ALARM_FLAG])
      alarm_flag <= 1'b0;
    else if (status_read & auto_clear_on_read)
      alarm_flag <= 1'b0;
  end

  // single event level, dropped once the flag is gone or mode changes
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      latched_low <= 1'b0;
    else if (single_fire)
      latched_low <= 1'b1;
    else if (~alarm_flag | repeat_select)
      latched_low <= 1'b0;
  end

  // pulse length counted in ticks so it does not depend on ref clock
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pulse_cnt <= PULSE_ZERO;
    else if (repeat_fire)
      pulse_cnt <= `PULSE_TICKS;
    else if (tick & pulse_busy)
      pulse_cnt <= pulse_cnt - 1'b1;
  end

  // registered pin, so decode glitches never reach the host
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      interrupt_or_freq_pin_n_o <= 1'b1;
    else
      interrupt_or_freq_pin_n_o <=
        ~((latched_low & alarm_flag) | pulse_busy);
  end

  // read mux, unmapped reads as zero
  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `ADDR_ALARM_SECONDS: next_rdata = alarm_seconds;
      `ADDR_ALARM_MINUTES: next_rdata = alarm_minutes;
      `ADDR_ALARM_HOURS: next_rdata = alarm_hours;
      `ADDR_ALARM_DATE: next_rdata = alarm_date;
      `ADDR_ALARM_MONTH: next_rdata = alarm_month;
      `ADDR_ALARM_WEEKDAY: next_rdata = alarm_weekday;
      `ADDR_STATUS:
      begin
        next_rdata[`BIT_AUTO_CLEAR] = auto_clear_on_read;
        next_rdata[`BIT_ALARM_FLAG] = alarm_flag;
      end
      `ADDR_INT_CTRL:
      begin
        next_rdata[`BIT_REPEAT_SELECT] = repeat_select;
        next_rdata[`BIT_FREQ_OUT_EN] = freq_out_en;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
  end
endmodule // rtc_alarm_compare

// *** hdl/rtc_alarm_map.vh ***
`ifndef RTC_ALARM_MAP_VH
`define RTC_ALARM_MAP_VH
// register addresses
`define ADDR_ALARM_SECONDS 8'h10
`define ADDR_ALARM_MINUTES 8'h11
`define ADDR_ALARM_HOURS 8'h12
`define ADDR_ALARM_DATE 8'h13
`define ADDR_ALARM_MONTH 8'h14
`define ADDR_ALARM_WEEKDAY 8'h15
`define ADDR_STATUS 8'h08
`define ADDR_INT_CTRL 8'h18
// field positions
`define BIT_MATCH_ENABLE 7
`define BIT_AUTO_CLEAR 7
`define BIT_ALARM_FLAG 0
`define BIT_REPEAT_SELECT 0
`define BIT_FREQ_OUT_EN 1
// reset values
`define RST_ALARM_BYTE 8'h00
`define RST_STATUS 8'h00
`define RST_INT_CTRL 8'h02
// repeat pulse width in timekeeping ticks
`define PULSE_TICKS 8'h01
`define PULSE_CNT_W 8
`endif

// *** hdl/byte_match.v ***
`timescale 1ns/1ps
module byte_match
(
  // alarm and calendar byte
  input wire [7:0] alarm_byte_i,
  input wire [6:0] calendar_byte_i,
  // result
  output wire enabled_o,
  output wire equal_o
);
  assign enabled_o = alarm_byte_i[7];
  assign equal_o = ~alarm_byte_i[7] | (alarm_byte_i[6:0] == calendar_byte_i);
endmodule // byte_match

// *** hdl/edge_sync.v ***
`timescale 1ns/1ps
module edge_sync
(
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire async_i,
  output reg rise_o
);
  reg meta;
  reg sync;
  reg last;
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      meta <= async_i;
      sync <= meta;
      last <= sync;
      rise_o <= sync & ~last;
    end
  end
endmodule // edge_sync

// *** tb/cal_source.sv ***
`timescale 1ns/1ps
module cal_source #(parameter int HALF = 20)
(
  // clock
  input wire ref_clk_i,
  // tick and calendar
  output logic tick_o = 1'h0,
  output logic [6:0] sec_o = 7'h00,
  output logic [6:0] min_o = 7'h00
);
  int n = 0;
  wire up = n == HALF - 1 && !tick_o;
  always @(posedge ref_clk_i)
  begin
    n <= n == HALF - 1 ? 0 : n + 1;
    if (n == HALF - 1)
      tick_o <= ~tick_o;
    // bcd count, calendar moves only with the rising tick
    if (up)
      sec_o <= sec_o == 7'h59 ? 7'h00 :
        sec_o + (sec_o[3:0] == 4'h9 ? 7'h07 : 7'h01);
    if (up && sec_o == 7'h59)
      min_o <= min_o + 7'h01;
  end
endmodule // cal_source

// *** tb/rtc_alarm_monitor.sv ***
`timescale 1ns/1ps
module rtc_alarm_monitor #(parameter int PER = 40)
(
  // clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // watched ports
  input wire tick_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire interrupt_or_freq_pin_n_o
);
  localparam int LO = PER - 2;
  localparam int HI = PER + 2;
  logic rep, fen, ac;
  int ts, lc;
  wire p = interrupt_or_freq_pin_n_o;
  wire st = reg_addr_i == 8'h08;
  wire clr = st && (reg_wr_i && !reg_wdata_i[0] || reg_rd_i && ac);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      rep <= 1'h0;
      fen <= 1'h1;
      ac <= 1'h0;
      ts <= 0;
      lc <= 0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == 8'h18)
        {fen, rep} <= reg_wdata_i[1:0];
      if (reg_wr_i && st)
        ac <= reg_wdata_i[7];
      ts <= $rose(tick_i) ? 0 : ts + 1;
      // width taken on the pin itself, not on the flag
      lc <= p ? 0 : lc + 1;
    end
  status_read_a: assert property (reg_rd_i && st |=>
    reg_rdata_o[7] == ac && reg_rdata_o[6:1] == 6'h00) else $error("status");
  ctrl_read_a: assert property (reg_rd_i && reg_addr_i == 8'h18
    |=> reg_rdata_o[1:0] == {fen, rep}) else $error("ctrl");
  unmapped_zero_a: assert property (reg_rd_i && !(reg_addr_i inside
    {8'h08, [8'h10:8'h15], 8'h18}) |=> reg_rdata_o == 8'h00) else $error("map");
  fire_delay_a: assert property ($fell(p) |-> ts inside {[2:7]})
    else $error("fire time");
  freq_block_a: assert property (fen && p |=> p)
    else $error("fire with freq out");
  single_hold_a: assert property (!rep && !p && !clr && !$past(clr)
    |=> !p) else $error("early release");
  clear_release_a: assert property (!rep && !p && clr |-> ##2 p)
    else $error("stuck low");
  pulse_width_a: assert property (rep && $rose(p) |-> lc inside {[LO:HI]})
    else $error("pulse width");
endmodule // rtc_alarm_monitor

// *** tb/rtc_alarm_compare_test.sv ***
`timescale 1ns/1ps
module rtc_alarm_compare_test;
  logic ref_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic reg_wr_i = 1'h0;
  logic reg_rd_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [6:0] cal_hours_i = 7'h11;
  logic [6:0] cal_date_i = 7'h01;
  logic [6:0] cal_month_i = 7'h01;
  logic [6:0] cal_weekday_i = 7'h03;
  wire tick_i;
  wire interrupt_or_freq_pin_n_o;
  wire [7:0] reg_rdata_o;
  wire [6:0] cal_seconds_i, cal_minutes_i;
  int fail_count = 0;
  int num_checks = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  cal_source cal_source_i (.ref_clk_i, .tick_o(tick_i),
    .sec_o(cal_seconds_i), .min_o(cal_minutes_i));
  rtc_alarm_compare rtc_alarm_compare_i (.*);
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("Error %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, exp);
  endtask
  // a minute of ticks fits inside the bound
  task automatic wait_pin(input logic lvl);
    int n = 0;
    while (interrupt_or_freq_pin_n_o !== lvl && n < 3000)
    begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    chk(interrupt_or_freq_pin_n_o, lvl);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #300000;
    fail_count++;
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rd(8'h10, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h18, 8'h02);
    rd(8'h16, 8'h00);
    $display("reset test done");
    wr(8'h15, 8'h83);
    repeat (100) @(posedge ref_clk_i);
    #1 chk(interrupt_or_freq_pin_n_o, 1'h1);
    rd(8'h08, 8'h00);
    wr(8'h15, 8'h00);
    $display("freq block test done");
    wr(8'h18, 8'h00);
    wr(8'h11, 8'h81);
    wr(8'h12, 8'h91);
    rd(8'h11, 8'h81);
    wait_pin(1'h0);
    chk(cal_seconds_i, 8'h00);
    chk(cal_minutes_i, 8'h01);
    rd(8'h08, 8'h01);
    repeat (100) @(posedge ref_clk_i);
    #1 chk(interrupt_or_freq_pin_n_o, 1'h0);
    wr(8'h08, 8'h00);
    repeat (3) @(posedge ref_clk_i);
    #1 chk(interrupt_or_freq_pin_n_o, 1'h1);
    $display("single test done");
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    wr(8'h08, 8'h80);
    wr(8'h10, 8'hB0);
    wait_pin(1'h0);
    chk(cal_seconds_i, 8'h30);
    rd(8'h08, 8'h81);
    rd(8'h08, 8'h80);
    @(posedge ref_clk_i);
    #1 chk(interrupt_or_freq_pin_n_o, 1'h1);
    $display("auto clear test done");
    wr(8'h08, 8'h00);
    wr(8'h18, 8'h01);
    wr(8'h10, 8'hC5);
    wait_pin(1'h0);
    wait_pin(1'h1);
    wait_pin(1'h0);
    rd(8'h08, 8'h01);
    $display("repeat test done");
    report_and_stop;
  end
endmodule // rtc_alarm_compare_test
bind rtc_alarm_compare rtc_alarm_monitor rtc_alarm_monitor_i (.*);
